//--- cdsit_pkg.sv
`default_nettype none

package cdsit_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register bus geometry and offsets
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_CTRL1 = 8'h00;
   localparam logic [7:0] ADDR_CTRL2 = 8'h01;
   localparam logic [7:0] ADDR_TMRCTRL = 8'h0F;
   localparam logic [7:0] ADDR_T2CLK = 8'h12;
   localparam logic [7:0] ADDR_T2VAL = 8'h13;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h21;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h22;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int BIT_SEC_EN = 2;
   localparam int BIT_T2_IRQ_EN = 0;
   localparam int BIT_T2_FLAG = 5;
   localparam int BIT_SEC_FLAG = 7;
   localparam int BIT_T2_RUN = 0;
   localparam int BIT_T2_PMODE = 5;
   localparam int BIT_T1_PMODE = 7;
   localparam int SRC_LSB = 0;
   localparam int PWSEL_LSB = 4;
   localparam int STAT_T2 = 0;
   localparam int STAT_SEC = 1;

   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] RESET_IRQ_EN = 2'h0;
   localparam logic [7:0] COUNT_ONE = 8'h01;

   ////////////////////////////////////////////////////////////////////////////
   // timer source clock choices
   typedef enum logic [2:0] {
      SRC_4096 = 3'b000,
      SRC_64 = 3'b001,
      SRC_1 = 3'b010,
      SRC_MIN = 3'b011,
      SRC_HOUR = 3'b111
   } cdsit_src_type;

   ////////////////////////////////////////////////////////////////////////////
   // pulse widths in microseconds, and their cycle counts at 25 MHz
   localparam int unsigned CLOCK_PERIOD_NS = 32'h0000_0028;
   localparam int unsigned NS_PER_US = 32'h0000_03E8;
   localparam int unsigned PW_122_US = 32'h0000_007A;
   localparam int unsigned PW_244_US = 32'h0000_00F4;
   localparam int unsigned PW_7812_US = 32'h0000_1E84;
   localparam int unsigned PW_15625_US = 32'h0000_3D09;
   localparam int unsigned PW122_CYC = PW_122_US * NS_PER_US / CLOCK_PERIOD_NS;
   localparam int unsigned PW244_CYC = PW_244_US * NS_PER_US / CLOCK_PERIOD_NS;
   localparam int unsigned PW7812_CYC = PW_7812_US * NS_PER_US / CLOCK_PERIOD_NS;
   localparam int unsigned PW15625_CYC = PW_15625_US * NS_PER_US / CLOCK_PERIOD_NS;

endpackage

`default_nettype wire

//--- cdsit_pulse.sv
`default_nettype none

module cdsit_pulse
   import cdsit_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic abort,
   input wire logic [31:0] width,
   output logic active
);

   logic [31:0] remain;

   ////////////////////////////////////////////////////////////////////////////
   // start wins over abort: a flag set in the clearing cycle stays set,
   // so its pulse must still run
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         active <= 1'b0;
         remain <= 32'h0000_0000;
      end else if (start) begin
         active <= 1'b1;
         remain <= width;
      end else if (abort) begin
         active <= 1'b0;
      end else if (active) begin
         active <= (remain > 32'h0000_0001);
         remain <= remain - 32'h0000_0001;
      end
   end

endmodule

`default_nettype wire

//--- cdsit_timer.sv
`default_nettype none

module cdsit_timer
   import cdsit_pkg::*;
#(
   parameter int unsigned PW244_CYCLES = PW244_CYC,
   parameter int unsigned PW7812_CYCLES = PW7812_CYC,
   parameter int unsigned PW15625_CYCLES = PW15625_CYC
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic tick4096,
   input wire logic tick64,
   input wire logic tick1,
   input wire logic tickMinute,
   input wire logic tickHour,
   output logic int1Low,
   output logic int2Low,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // software-visible state
   logic secondsIrqEnable;
   logic timer2IrqEnable;
   logic timer2RunEnable;
   logic timer2PulseMode;
   logic timer1PulseMode;
   logic [2:0] timer2SrcSel;
   logic [2:0] timer2PulseWidthSel;
   logic [7:0] reloadValue;
   logic [1:0] irqEnable;

   // block state
   logic [7:0] count;
   logic timer2Flag;
   logic secondsFlag;
   logic t2Pulse;
   logic secPulse;

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   wire selCtrl1 = (regAddr == ADDR_CTRL1);
   wire selCtrl2 = (regAddr == ADDR_CTRL2);
   wire selTmrCtrl = (regAddr == ADDR_TMRCTRL);
   wire selT2Clk = (regAddr == ADDR_T2CLK);
   wire selT2Val = (regAddr == ADDR_T2VAL);
   wire selIrqStat = (regAddr == ADDR_IRQ_STAT);
   wire selIrqClr = (regAddr == ADDR_IRQ_CLR);
   wire selIrqEn = (regAddr == ADDR_IRQ_EN);

   wire wrCtrl1 = regWrite & selCtrl1;
   wire wrCtrl2 = regWrite & selCtrl2;
   wire wrTmrCtrl = regWrite & selTmrCtrl;
   wire wrT2Clk = regWrite & selT2Clk;
   wire writeReload = regWrite & selT2Val;
   wire wrIrqClr = regWrite & selIrqClr;
   wire wrIrqEn = regWrite & selIrqEn;

   ////////////////////////////////////////////////////////////////////////////
   // flag clears: a zero written to a flag bit of control 2, or a one
   // written to the matching bit of the clear register
   wire clrT2 = (wrCtrl2 & ~regWrData[BIT_T2_FLAG]) | (wrIrqClr & regWrData[STAT_T2]);
   wire clrSec = (wrCtrl2 & ~regWrData[BIT_SEC_FLAG]) | (wrIrqClr & regWrData[STAT_SEC]);

   ////////////////////////////////////////////////////////////////////////////
   // control register writes; each takes effect at the next edge only
   // writes registered first
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         secondsIrqEnable <= 1'b0;
         timer2IrqEnable <= 1'b0;
      end else begin
         if (wrCtrl1) begin
            secondsIrqEnable <= regWrData[BIT_SEC_EN];
         end
         if (wrCtrl2) begin
            timer2IrqEnable <= regWrData[BIT_T2_IRQ_EN];
         end
      end
   end

   // timer run and pulse-mode control, source and width selection
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         timer2RunEnable <= 1'b0;
         timer2PulseMode <= 1'b0;
         timer1PulseMode <= 1'b0;
         timer2SrcSel <= 3'h0;
         timer2PulseWidthSel <= 3'h0;
      end else begin
         if (wrTmrCtrl) begin
            timer2RunEnable <= regWrData[BIT_T2_RUN];
            timer2PulseMode <= regWrData[BIT_T2_PMODE];
            timer1PulseMode <= regWrData[BIT_T1_PMODE];
         end
         if (wrT2Clk) begin
            timer2SrcSel <= regWrData[SRC_LSB +: 3];
            timer2PulseWidthSel <= regWrData[PWSEL_LSB +: 3];
         end
      end
   end

   // reload value and interrupt enables
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reloadValue <= RESET_BYTE;
         irqEnable <= RESET_IRQ_EN;
      end else begin
         if (writeReload) begin
            reloadValue <= regWrData;
         end
         if (wrIrqEn) begin
            irqEnable <= regWrData[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // source clock selection; the four top codes all pick the hourly tick
   wire srcTick = (timer2SrcSel == SRC_4096) ? tick4096 :
                  (timer2SrcSel == SRC_64) ? tick64 :
                  (timer2SrcSel == SRC_1) ? tick1 :
                  (timer2SrcSel == SRC_MIN) ? tickMinute : tickHour;

   // end of a period: a reload write in the same cycle takes precedence
   // expiry at count one
   wire periodEnd = timer2RunEnable & srcTick & (count == COUNT_ONE) & ~writeReload;

   ////////////////////////////////////////////////////////////////////////////
   // countdown counter; halted it sits at the reload value so the next
   // start begins a whole period
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         count <= RESET_BYTE;
      end else if (writeReload) begin
         count <= regWrData;
      end else if (!timer2RunEnable) begin
         count <= reloadValue;
      end else if (srcTick && count != RESET_BYTE) begin
         count <= (count == COUNT_ONE) ? reloadValue : count - COUNT_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky flags: a set in the clearing cycle wins
   wire secondsEvent = tick1 & secondsIrqEnable;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         timer2Flag <= 1'b0;
         secondsFlag <= 1'b0;
      end else begin
         timer2Flag <= (timer2Flag & ~clrT2) | periodEnd;
         secondsFlag <= (secondsFlag & ~clrSec) | secondsEvent;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pulse width for the countdown timer, chosen from the source and the
   // reload value; the field gives whole 1/64 s steps
   function automatic logic [31:0] t2Width(
      input logic [2:0] src,
      input logic [7:0] reload,
      input logic [2:0] sel
   );
      logic [31:0] steps;
      logic [31:0] fieldWidth;
      steps = 32'(sel) + 32'h0000_0001;
      fieldWidth = 32'(steps * PW15625_CYCLES);
      case (src)
         SRC_4096: t2Width = (reload == COUNT_ONE) ? 32'(PW122_CYC) : 32'(PW244_CYCLES);
         SRC_64: t2Width = (reload == COUNT_ONE) ? 32'(PW7812_CYCLES) :
                           (steps > 32'(reload)) ? 32'(PW15625_CYCLES) : fieldWidth;
         default: t2Width = fieldWidth;
      endcase
   endfunction

   wire [31:0] timer2PulseWidth = t2Width(timer2SrcSel, reloadValue, timer2PulseWidthSel);

   // countdown pulse, restarted each period and cut short by a flag clear
   cdsit_pulse timer2PulseGen (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(periodEnd),
      .abort(clrT2),
      .width(timer2PulseWidth),
      .active(t2Pulse)
   );

   cdsit_pulse secondsPulseGen (
      .clock(clock),
      .sys_rst(sys_rst),
      .start(secondsEvent),
      .abort(clrSec),
      .width(32'(PW15625_CYCLES)),
      .active(secPulse)
   );

   ////////////////////////////////////////////////////////////////////////////
   // interrupt line selection
   // pulse or level, enable gates
   wire t2Irq = timer2IrqEnable & (timer2PulseMode ? t2Pulse : timer2Flag);
   wire secIrq = secondsIrqEnable & (timer1PulseMode ? secPulse : secondsFlag);
   wire [1:0] irqStatus = {secondsFlag, timer2Flag};

   // lines driven from flops so no glitch from the select mux reaches a pin
   // timer interrupt on both lines, seconds interrupt on int1Low only
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         int1Low <= 1'b1;
         int2Low <= 1'b1;
         irq <= 1'b0;
      end else begin
         int1Low <= ~(t2Irq | secIrq);
         int2Low <= ~t2Irq;
         irq <= |(irqStatus & irqEnable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; unmapped and write-only addresses read zero
   wire [7:0] ctrl1Read = 8'(secondsIrqEnable) << BIT_SEC_EN;
   wire [7:0] ctrl2Read = (8'(timer2IrqEnable) << BIT_T2_IRQ_EN) |
                          (8'(timer2Flag) << BIT_T2_FLAG) |
                          (8'(secondsFlag) << BIT_SEC_FLAG);
   wire [7:0] tmrCtrlRead = (8'(timer2RunEnable) << BIT_T2_RUN) |
                            (8'(timer2PulseMode) << BIT_T2_PMODE) |
                            (8'(timer1PulseMode) << BIT_T1_PMODE);
   wire [7:0] t2ClkRead = (8'(timer2SrcSel) << SRC_LSB) |
                          (8'(timer2PulseWidthSel) << PWSEL_LSB);
   wire [7:0] next_regRdData = selCtrl1 ? ctrl1Read :
                               selCtrl2 ? ctrl2Read :
                               selTmrCtrl ? tmrCtrlRead :
                               selT2Clk ? t2ClkRead :
                               selT2Val ? count :
                               selIrqStat ? 8'(irqStatus) :
                               selIrqEn ? 8'(irqEnable) : RESET_BYTE;

   // the count cannot be frozen for a read, so a host compares two reads
   // count sampled unfrozen
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         regRdData <= RESET_BYTE;
      end else if (regRead) begin
         regRdData <= next_regRdData;
      end else begin
         regRdData <= RESET_BYTE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   a_reload_on_expiry: assert property (
      periodEnd |=> (count == $past(reloadValue)) && timer2Flag)
      else $error("counter did not reload and flag at period end");

   a_count_decrements: assert property (
      timer2RunEnable && srcTick && count > COUNT_ONE && !writeReload
      |=> count == $past(count) - COUNT_ONE)
      else $error("counter did not decrement on source tick");

   a_halt_when_off: assert property (
      !timer2RunEnable && !writeReload |=> count == $past(reloadValue) && !$rose(timer2Flag))
      else $error("halted timer moved or flagged");

   a_reload_immediate: assert property (
      writeReload |=> count == $past(regWrData))
      else $error("reload write not applied at once");

   a_zero_stops: assert property (
      count == RESET_BYTE && !writeReload |=> count == RESET_BYTE && !$rose(timer2Flag))
      else $error("zero reload did not stop the timer");

   a_flag_sticky: assert property (
      timer2Flag && !clrT2 |=> timer2Flag)
      else $error("timer flag dropped without host clear");

   a_seconds_gate: assert property (
      !secondsIrqEnable && !secondsFlag && !wrCtrl1 |=> !secondsFlag && !secIrq)
      else $error("seconds flag set while disabled");

   a_seconds_sticky: assert property (
      secondsFlag && !clrSec |=> secondsFlag)
      else $error("seconds flag dropped without host clear");

   a_both_lines: assert property (
      t2Irq |=> !int1Low && !int2Low)
      else $error("interrupt lines not asserted together");

   a_level_holds: assert property (
      secondsIrqEnable && !timer1PulseMode && secondsFlag |=> !int1Low)
      else $error("seconds level interrupt not held");

   a_pulse_cut: assert property (
      clrT2 && !periodEnd |=> !t2Pulse)
      else $error("timer pulse not ended by flag clear");

   a_live_readback: assert property (
      regRead && selT2Val |=> regRdData == $past(count))
      else $error("timer value read not the live count");

   a_int2_gated: assert property (
      !t2Irq |=> int2Low)
      else $error("timer line asserted without enabled interrupt");

   a_level_follows: assert property (
      timer2IrqEnable && !timer2PulseMode && timer2Flag |=> !int2Low)
      else $error("timer level interrupt not following flag");

   a_seconds_pulse: assert property (
      secondsEvent |=> secPulse)
      else $error("seconds pulse not started on seconds tick");

   a_seconds_cut: assert property (
      clrSec && !secondsEvent |=> !secPulse)
      else $error("seconds pulse not ended by flag clear");

endmodule

`default_nettype wire

//--- cdsit_prescaler_model.sv
`default_nettype none

// stand-in for the crystal prescaler feeding the timer block
module cdsit_prescaler_model (
   input wire logic clock,
   input wire logic sys_rst,
   output logic tick4096,
   output logic tick64,
   output logic tick1,
   output logic tickMinute,
   output logic tickHour
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [8:0] divCount;

   // one shared divider; rates scaled down so a run stays short
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         divCount <= 9'h000;
      end else begin
         divCount <= divCount + 9'h001;
      end
   end

   // slower ticks land on faster ones, as a real ripple prescaler does
   assign tick4096 = (divCount[3:0] == 4'hf);
   assign tick64 = (divCount[5:0] == 6'h3f);
   assign tick1 = (divCount[6:0] == 7'h7f);
   assign tickMinute = (divCount[7:0] == 8'hff);
   assign tickHour = (divCount == 9'h1ff);
endmodule

`default_nettype wire

//--- tb_top.sv
`default_nettype none

module tb_top;
   import cdsit_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdData;
   logic t4096, t64, t1, tMin, tHour;
   logic int1Low, int2Low, irq;
   int numErrors = 0;
   int checkCount = 0;
   int cycles = 0;
   logic [7:0] v, v2;
   int w;
   logic [7:0] addrList [9] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_TMRCTRL, ADDR_T2CLK, ADDR_T2VAL,
      ADDR_IRQ_STAT, ADDR_IRQ_CLR, ADDR_IRQ_EN, 8'h55};
   // {width sel, source}, reload and expected low width in cycles
   logic [7:0] cfgClk [7] = '{8'h00, 8'h01, 8'h11, 8'h21, 8'h02, 8'h03, 8'h07};
   logic [7:0] cfgN [7] = '{8'h02, 8'h01, 8'h02, 8'h02, 8'h01, 8'h01, 8'h01};
   int cfgW [7] = '{20, 10, 80, 40, 40, 40, 40};

   ////////////////////////////////////////////////////////////////////////////
   // small pulse widths keep the run short: 244 us, 7.812 ms, 15.625 ms
   cdsit_timer #(.PW244_CYCLES(20), .PW7812_CYCLES(10), .PW15625_CYCLES(40)) i_dut (
      .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .tick4096(t4096),
      .tick64(t64), .tick1(t1), .tickMinute(tMin), .tickHour(tHour),
      .int1Low(int1Low), .int2Low(int2Low), .irq(irq));

   cdsit_prescaler_model i_pre (
      .clock(clock), .sys_rst(sys_rst), .tick4096(t4096), .tick64(t64), .tick1(t1),
      .tickMinute(tMin), .tickHour(tHour));

   // 25 MHz clock and a hang guard; the tests need a few thousand cycles
   always #20 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         numErrors++;
         completeRun();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic completeRun();
      if (numErrors == 0 && checkCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         numErrors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle strobes, changed just after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask

   // read data stands only in the cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   // returns just after the n-th fast tick has been taken
   task automatic waitTick(input int n);
      repeat (n) begin
         @(negedge clock);
         while (t4096 !== 1'b1) @(negedge clock);
         @(posedge clock);
      end
      #1;
   endtask

   task automatic settle();
      repeat (2) @(posedge clock);
      #1;
   endtask

   // bounded wait for an interrupt line to go low
   task automatic waitLow(input bit line2);
      int k = 0;
      while ((line2 ? int2Low : int1Low) !== 1'b0 && k < 3000) begin
         @(posedge clock);
         #1 k++;
      end
   endtask

   task automatic pulseWidth(input bit line2, output int n);
      n = 0;
      waitLow(line2);
      while ((line2 ? int2Low : int1Low) === 1'b0 && n < 3000) begin
         @(posedge clock);
         #1 n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      // reset state, write-only and unmapped reads give zero
      foreach (addrList[i]) rdChk(addrList[i], 8'h00);
      chk({int1Low, int2Low, irq}, 3'b110);
      wr(8'h55, 8'hff);
      // level mode countdown from 3 at the fast source
      wr(ADDR_T2VAL, 8'h03);
      wr(ADDR_T2CLK, 8'h00);
      wr(ADDR_CTRL2, 8'h01);
      wr(ADDR_IRQ_EN, 8'h01);
      waitTick(2);
      rdChk(ADDR_T2VAL, 8'h03);
      wr(ADDR_TMRCTRL, 8'h01);
      waitTick(1);
      rd(ADDR_T2VAL, v);
      rd(ADDR_T2VAL, v2);
      chk(v2, v);
      chk(v, 8'h02);
      waitTick(1);
      rdChk(ADDR_T2VAL, 8'h01);
      waitTick(1);
      rdChk(ADDR_IRQ_STAT, 8'h01);
      chk({int1Low, int2Low, irq}, 3'b001);
      rdChk(ADDR_T2VAL, 8'h03);
      waitTick(7);
      rdChk(ADDR_CTRL2, 8'h21);
      rdChk(ADDR_CTRL2, 8'h21);
      // masking the summary output only
      wr(ADDR_IRQ_EN, 8'h00);
      settle();
      chk({int1Low, int2Low, irq}, 3'b000);
      wr(ADDR_IRQ_EN, 8'h01);
      settle();
      chk(irq, 1'b1);
      // interrupt enable off gates both lines, flag untouched
      wr(ADDR_CTRL2, 8'h20);
      settle();
      chk({int1Low, int2Low}, 2'b11);
      rdChk(ADDR_IRQ_STAT, 8'h01);
      wr(ADDR_TMRCTRL, 8'h00);
      wr(ADDR_CTRL2, 8'h01);
      settle();
      rdChk(ADDR_IRQ_STAT, 8'h00);
      chk({int1Low, int2Low, irq}, 3'b110);
      // reload rewritten mid-period, then reload of zero
      wr(ADDR_TMRCTRL, 8'h01);
      waitTick(1);
      wr(ADDR_T2VAL, 8'h05);
      rdChk(ADDR_T2VAL, 8'h05);
      wr(ADDR_T2VAL, 8'h00);
      waitTick(8);
      rdChk(ADDR_IRQ_STAT, 8'h00);
      rdChk(ADDR_T2VAL, 8'h00);
      // pulse widths for every source, width field and fallback
      for (int i = 0; i < 7; i++) begin
         wr(ADDR_TMRCTRL, 8'h00);
         wr(ADDR_IRQ_CLR, 8'h01);
         wr(ADDR_T2CLK, cfgClk[i]);
         wr(ADDR_T2VAL, cfgN[i]);
         wr(ADDR_TMRCTRL, 8'h21);
         pulseWidth(1'b1, w);
         chk(w, cfgW[i]);
      end
      // clearing mid-pulse cuts it short
      wr(ADDR_TMRCTRL, 8'h00);
      wr(ADDR_IRQ_CLR, 8'h01);
      wr(ADDR_T2CLK, 8'h11);
      wr(ADDR_T2VAL, 8'h02);
      wr(ADDR_TMRCTRL, 8'h21);
      waitLow(1'b1);
      wr(ADDR_IRQ_CLR, 8'h01);
      @(posedge clock);
      #1 chk({int1Low, int2Low}, 2'b11);
      // seconds generator, disabled then pulsed then level
      wr(ADDR_TMRCTRL, 8'h00);
      wr(ADDR_CTRL2, 8'h00);
      wr(ADDR_IRQ_CLR, 8'h03);
      repeat (300) @(posedge clock);
      rdChk(ADDR_IRQ_STAT, 8'h00);
      chk({int1Low, int2Low}, 2'b11);
      wr(ADDR_IRQ_EN, 8'h02);
      wr(ADDR_TMRCTRL, 8'h80);
      wr(ADDR_CTRL1, 8'h04);
      pulseWidth(1'b0, w);
      chk(w, 40);
      rdChk(ADDR_IRQ_STAT, 8'h02);
      chk({int2Low, irq}, 2'b11);
      wr(ADDR_TMRCTRL, 8'h00);
      waitLow(1'b0);
      repeat (200) @(posedge clock);
      #1 chk(int1Low, 1'b0);
      // clear away from a seconds tick, whose set would win over the clear
      @(negedge clock);
      while (t1 !== 1'b1) @(negedge clock);
      @(posedge clock);
      wr(ADDR_IRQ_CLR, 8'h02);
      @(posedge clock);
      #1 chk(int1Low, 1'b1);
      completeRun();
   end
endmodule

`default_nettype wire
